//--- core/mctm_pkg.sv
`default_nettype none
package mctm_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 64;

    localparam logic [11:0] ADDR_MC_STATE = 12'h17a;
    localparam logic [11:0] ADDR_PERF_STS = 12'h198;
    localparam logic [11:0] ADDR_PERF_CTL = 12'h199;
    localparam logic [11:0] ADDR_CLK_MOD = 12'h19a;
    localparam logic [11:0] ADDR_THERM_INT = 12'h19b;
    localparam logic [11:0] ADDR_THERM_STS = 12'h19c;
    localparam logic [11:0] ADDR_MODE_SEL = 12'h19d;
    localparam logic [11:0] ADDR_MISC_EN = 12'h1a0;
    localparam logic [11:0] ADDR_EVT_STS = 12'h1f0;
    localparam logic [11:0] ADDR_EVT_MASK = 12'h1f1;

    // Machine-check global state fields
    localparam int unsigned MC_RESTART_BIT = 0;
    localparam int unsigned MC_IP_VALID_BIT = 1;
    localparam int unsigned MC_IN_PROG_BIT = 2;
    localparam int unsigned MC_FIELD_W = 3;

    localparam int unsigned MODE_SEL_BIT = 16;
    localparam int unsigned AUTO_THERM_EN_BIT = 3;

    // Thermal monitor state fields
    localparam int unsigned THS_TRIP_BIT = 0;
    localparam int unsigned THS_LOG_BIT = 1;
    localparam int unsigned THS_W = 2;

    // Event status / mask layout
    localparam int unsigned EVT_MC_BIT = 0;
    localparam int unsigned EVT_SHUT_BIT = 1;
    localparam int unsigned EVT_TRIP_BIT = 2;
    localparam int unsigned EVT_W = 3;

    localparam logic [63:0] RST_WORD = 64'h0;

    typedef struct packed {
        logic duty_cycle_thermal_mode;
        logic freq_transition_thermal_mode;
        logic clk_run_en;
    } mctm_therm_t;
endpackage
`default_nettype wire

//--- core/mctm_msrs.sv
// Function
// - A machine-check event sets the in-progress flag, bit 2 of global state.
// - A machine-check event while in-progress is set enters shutdown, no exception.
// - Mode select bit 16 at zero selects duty-cycle thermal mode.
// - Mode select bit at one selects frequency-transition thermal mode.
// - With enable bit 3 clear, neither thermal mode is active.
// - Feature enable register at 1A0 is read/write; bits 2:0 reserved.
// - Clock modulation control register at 19AH is read/write.
// - Thermal interrupt control register at 19BH is read/write.
// - Thermal monitor state register at 19CH is read/write, shows state.
// - Performance-state status at 198H and control at 199H are decoded.
// - Enable bit 3 is read/write, enables thermal circuit, resets disabled.
// - Active circuit in duty-cycle mode forces clocks to 50% duty.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module mctm_msrs
    import mctm_pkg::*;
#(
    parameter int unsigned AW = ADDR_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Register port
    input wire logic [AW-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    // Machine-check events
    input wire logic mc_event,
    input wire logic mc_restart_ok,
    input wire logic mc_ip_valid,
    output logic mc_raise,
    output logic shutdown,
    // Thermal and performance state
    input wire logic therm_trip,
    input wire logic [DATA_W-1:0] perf_status_in,
    output mctm_therm_t therm,
    output logic [DATA_W-1:0] perf_ctl,
    output logic [DATA_W-1:0] clk_mod,
    output logic [DATA_W-1:0] therm_int,
    // Interrupt
    output logic irq
);
    logic [MC_FIELD_W-1:0] mc_state_ff, nxt_mc_state;
    logic shutdown_ff, mc_raise_ff;
    logic [DATA_W-1:0] perf_ctl_ff, clk_mod_ff, therm_int_ff;
    logic [THS_W-1:0] ths_ff, nxt_ths;
    logic mode_sel_ff, auto_en_ff;
    logic [EVT_W-1:0] evt_sts_ff, evt_mask_ff, nxt_evt_sts;
    logic trip_prev_ff;
    logic [DATA_W-1:0] rdata_ff;
    mctm_therm_t therm_ff, nxt_therm;
    logic irq_ff;

    // Address decode
    wire hit_mc = addr == ADDR_MC_STATE;
    wire hit_psts = addr == ADDR_PERF_STS;
    wire hit_pctl = addr == ADDR_PERF_CTL;
    wire hit_cmod = addr == ADDR_CLK_MOD;
    wire hit_tint = addr == ADDR_THERM_INT;
    wire hit_tsts = addr == ADDR_THERM_STS;
    wire hit_msel = addr == ADDR_MODE_SEL;
    wire hit_misc = addr == ADDR_MISC_EN;
    wire hit_ests = addr == ADDR_EVT_STS;
    wire hit_emsk = addr == ADDR_EVT_MASK;

    wire wr_mc = wr && hit_mc;
    wire wr_tsts = wr && hit_tsts;
    wire wr_ests = wr && hit_ests;

    // Machine-check handling
    wire in_prog = mc_state_ff[MC_IN_PROG_BIT];
    wire mc_second = mc_event && in_prog && !shutdown_ff;
    wire mc_first = mc_event && !in_prog && !shutdown_ff;

    always_comb begin
        nxt_mc_state = mc_state_ff;
        if (wr_mc) begin
            nxt_mc_state = wdata[MC_FIELD_W-1:0];
        end
        // Event beats a same-cycle software clear
        if (mc_first) begin
            nxt_mc_state[MC_IN_PROG_BIT] = 1'b1;
            nxt_mc_state[MC_RESTART_BIT] = mc_restart_ok;
            nxt_mc_state[MC_IP_VALID_BIT] = mc_ip_valid;
        end
    end

    // Thermal state
    wire trip_rise = therm_trip && !trip_prev_ff;
    wire circuit_on = auto_en_ff && therm_trip;

    always_comb begin
        nxt_ths = ths_ff;
        if (wr_tsts) begin
            nxt_ths[THS_LOG_BIT] = wdata[THS_LOG_BIT];
        end
        nxt_ths[THS_TRIP_BIT] = therm_trip;
        if (trip_rise) begin
            nxt_ths[THS_LOG_BIT] = 1'b1;
        end
    end

    always_comb begin
        nxt_therm = '0;
        // Neither mode without the enable bit
        nxt_therm.duty_cycle_thermal_mode = circuit_on && !mode_sel_ff;
        nxt_therm.freq_transition_thermal_mode = circuit_on && mode_sel_ff;
        // Alternate run and stop cycles for half duty
        nxt_therm.clk_run_en = 1'b1;
        if (nxt_therm.duty_cycle_thermal_mode) begin
            nxt_therm.clk_run_en = !therm_ff.clk_run_en;
        end
    end

    // Event status, write one to clear, set wins
    wire [EVT_W-1:0] evt_set = {trip_rise, mc_second, mc_first};
    wire [EVT_W-1:0] nxt_evt_mask = (wr && hit_emsk) ? wdata[EVT_W-1:0] : evt_mask_ff;

    always_comb begin
        nxt_evt_sts = evt_sts_ff;
        if (wr_ests) begin
            nxt_evt_sts = evt_sts_ff & ~wdata[EVT_W-1:0];
        end
        nxt_evt_sts = nxt_evt_sts | evt_set;
    end

    // Read mux, reserved and unmapped read zero
    wire [DATA_W-1:0] rd_mux =
        hit_mc ? {{(DATA_W-MC_FIELD_W){1'b0}}, mc_state_ff} :
        hit_psts ? perf_status_in :
        hit_pctl ? perf_ctl_ff :
        hit_cmod ? clk_mod_ff :
        hit_tint ? therm_int_ff :
        hit_tsts ? {{(DATA_W-THS_W){1'b0}}, ths_ff} :
        hit_msel ? (DATA_W'(mode_sel_ff) << MODE_SEL_BIT) :
        hit_misc ? (DATA_W'(auto_en_ff) << AUTO_THERM_EN_BIT) :
        hit_ests ? {{(DATA_W-EVT_W){1'b0}}, evt_sts_ff} :
        hit_emsk ? {{(DATA_W-EVT_W){1'b0}}, evt_mask_ff} :
        RST_WORD;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mc_state_ff <= '0;
            shutdown_ff <= 1'b0;
            mc_raise_ff <= 1'b0;
        end else begin
            mc_state_ff <= nxt_mc_state;
            mc_raise_ff <= mc_first;
            if (mc_second) begin
                shutdown_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            perf_ctl_ff <= RST_WORD;
            clk_mod_ff <= RST_WORD;
            therm_int_ff <= RST_WORD;
        end else begin
            if (wr && hit_pctl) begin
                perf_ctl_ff <= wdata;
            end
            if (wr && hit_cmod) begin
                clk_mod_ff <= wdata;
            end
            if (wr && hit_tint) begin
                therm_int_ff <= wdata;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mode_sel_ff <= 1'b0;
            auto_en_ff <= 1'b0;
        end else begin
            if (wr && hit_msel) begin
                mode_sel_ff <= wdata[MODE_SEL_BIT];
            end
            if (wr && hit_misc) begin
                auto_en_ff <= wdata[AUTO_THERM_EN_BIT];
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ths_ff <= '0;
            trip_prev_ff <= 1'b0;
            therm_ff <= '0;
        end else begin
            ths_ff <= nxt_ths;
            trip_prev_ff <= therm_trip;
            therm_ff <= nxt_therm;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            evt_sts_ff <= '0;
            evt_mask_ff <= '0;
            irq_ff <= 1'b0;
            rdata_ff <= RST_WORD;
        end else begin
            evt_sts_ff <= nxt_evt_sts;
            evt_mask_ff <= nxt_evt_mask;
            // Next-state terms keep irq exact right after a mask write
            irq_ff <= |(nxt_evt_sts & nxt_evt_mask);
            // Zero between reads so a stale word never looks valid
            rdata_ff <= rd ? rd_mux : RST_WORD;
        end
    end

    assign rdata = rdata_ff;
    assign mc_raise = mc_raise_ff;
    assign shutdown = shutdown_ff;
    assign therm = therm_ff;
    assign perf_ctl = perf_ctl_ff;
    assign clk_mod = clk_mod_ff;
    assign therm_int = therm_int_ff;
    assign irq = irq_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_mc_first_sets: assert property (
        mc_event && !in_prog && !shutdown_ff |=> in_prog && mc_raise
    ) else $error("in-progress flag not set on event");

    a_second_shutdown: assert property (
        mc_event && in_prog |=> shutdown && !mc_raise
    ) else $error("second machine check did not shut down");

    a_shutdown_sticks: assert property (
        shutdown |=> shutdown
    ) else $error("shutdown state left");

    a_no_mode_off: assert property (
        !auto_en_ff |=> !therm.duty_cycle_thermal_mode && !therm.freq_transition_thermal_mode
    ) else $error("thermal mode active while disabled");

    a_mode_sel_map: assert property (
        auto_en_ff && therm_trip |=> therm.freq_transition_thermal_mode == $past(mode_sel_ff)
            && therm.duty_cycle_thermal_mode == !$past(mode_sel_ff)
    ) else $error("mode select mapping wrong");

    a_duty_half_cycle: assert property (
        therm.duty_cycle_thermal_mode ##1 therm.duty_cycle_thermal_mode
            |-> therm.clk_run_en != $past(therm.clk_run_en)
    ) else $error("clock run enable not alternating");

    a_misc_readback: assert property (
        rd && hit_misc |=> rdata == (DATA_W'($past(auto_en_ff)) << AUTO_THERM_EN_BIT)
    ) else $error("feature enable readback wrong");

    a_msel_readback: assert property (
        rd && hit_msel |=> rdata[MODE_SEL_BIT-1:0] == '0 && rdata[DATA_W-1:MODE_SEL_BIT+1] == '0
    ) else $error("mode select reserved bits not zero");

    a_clkmod_rw: assert property (
        wr && hit_cmod ##1 rd && hit_cmod |=> rdata == $past(wdata, 2)
    ) else $error("clock modulation write lost");

    a_irq_level: assert property (
        irq == |(evt_sts_ff & evt_mask_ff)
    ) else $error("interrupt level mismatch");

    // Machine-check flag and shutdown entry
    a_raise_single: assert property (
        mc_raise |=> !mc_raise
    ) else $error("machine check raised twice in a row");

    a_mc_sts_logged: assert property (
        mc_event && !in_prog && !shutdown |=> evt_sts_ff[EVT_MC_BIT]
    ) else $error("first machine check not logged");

    a_clear_in_prog: assert property (
        wr_mc && !wdata[MC_IN_PROG_BIT] && !mc_event |=> !in_prog
    ) else $error("in-progress flag not cleared by write");

    a_shutdown_cause: assert property (
        !shutdown && !(mc_event && in_prog) |=> !shutdown
    ) else $error("shutdown without a second machine check");

    a_shutdown_no_raise: assert property (
        shutdown |-> !mc_raise
    ) else $error("exception raised in shutdown");

    a_second_logged: assert property (
        mc_event && in_prog && !shutdown |=> evt_sts_ff[EVT_SHUT_BIT]
    ) else $error("shutdown entry not logged");

    // Thermal modes; the cycle after reset still shows the reset word
    a_duty_needs_en: assert property (
        therm.duty_cycle_thermal_mode |-> $past(auto_en_ff && !mode_sel_ff)
    ) else $error("duty mode without enable");

    a_freq_needs_sel: assert property (
        therm.freq_transition_thermal_mode |-> $past(auto_en_ff && mode_sel_ff)
    ) else $error("frequency mode without select");

    a_freq_no_stop: assert property (
        therm.freq_transition_thermal_mode |-> therm.clk_run_en
    ) else $error("clock stopped in frequency mode");

    a_run_outside_duty: assert property (
        $past(nrst) && !therm.duty_cycle_thermal_mode |-> therm.clk_run_en
    ) else $error("clock stopped outside duty mode");

    a_trip_logged: assert property (
        therm_trip && !trip_prev_ff |=> ths_ff[THS_LOG_BIT] && evt_sts_ff[EVT_TRIP_BIT]
    ) else $error("thermal trip not logged");

    // Register port behaviour
    a_tsts_live: assert property (
        rd && hit_tsts |=> rdata[THS_TRIP_BIT] == $past(therm_trip, 2)
    ) else $error("thermal state trip bit stale");

    a_psts_read: assert property (
        rd && hit_psts |=> rdata == $past(perf_status_in)
    ) else $error("performance status readback wrong");

    a_pctl_rw: assert property (
        wr && hit_pctl ##1 rd && hit_pctl |=> rdata == $past(wdata, 2)
    ) else $error("performance control write lost");

    a_tint_rw: assert property (
        wr && hit_tint ##1 rd && hit_tint |=> rdata == $past(wdata, 2)
    ) else $error("thermal interrupt control write lost");

    a_rdata_idle: assert property (
        !rd |=> rdata == '0
    ) else $error("read data outside read cycle");

    c_mc_then_clear: cover property (mc_event ##[1:20] wr_mc && !wdata[MC_IN_PROG_BIT]);
    c_shutdown: cover property (mc_event ##[1:20] mc_event && shutdown_ff == 1'b0);
    c_duty_mode: cover property (therm.duty_cycle_thermal_mode [*4]);
    c_freq_mode: cover property (therm.freq_transition_thermal_mode && irq);
    c_irq_on: cover property (!irq ##1 irq);
endmodule
`default_nettype wire

//--- verification/mctm_msrs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mctm_msrs_tb;
    import mctm_pkg::*;
    logic mclk, nrst, wr, rd, mc_event, mc_restart_ok, mc_ip_valid, therm_trip, rd_pend;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, perf_status_in, perf_ctl, clk_mod, therm_int, v;
    logic [DATA_W-1:0] vals [3];
    logic [ADDR_W-1:0] rw_addr [3];
    logic [ADDR_W-1:0] rst_addr [9];
    logic mc_raise, shutdown, irq, prev_run;
    mctm_therm_t therm;
    logic [DATA_W-1:0] exp_q [$];
    logic [31:0] seed;
    int failures, samples_checked;

    mctm_msrs #(.AW(ADDR_W)) dut_u (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .mc_event(mc_event), .mc_restart_ok(mc_restart_ok),
        .mc_ip_valid(mc_ip_valid), .mc_raise(mc_raise), .shutdown(shutdown),
        .therm_trip(therm_trip), .perf_status_in(perf_status_in), .therm(therm),
        .perf_ctl(perf_ctl), .clk_mod(clk_mod), .therm_int(therm_int), .irq(irq));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic rnd(output logic [63:0] r);
        seed = xs(seed);
        r[63:32] = seed;
        seed = xs(seed);
        r[31:0] = seed;
    endtask

    task automatic cmp(input logic [63:0] g, input logic [63:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic conclude;
        if (failures == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [63:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [11:0] a, input logic [63:0] e);
        @(posedge mclk);
        exp_q.push_back(e);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
    endtask

    task automatic mc_pulse;
        @(posedge mclk);
        mc_event <= 1'b1;
        @(posedge mclk);
        mc_event <= 1'b0;
    endtask

    // Read data must stand only in the cycle after the strobe
    always @(posedge mclk) rd_pend <= rd;
    always @(negedge mclk) begin
        if (rd_pend === 1'b1) begin
            cmp(rdata, exp_q.pop_front());
        end else if (nrst === 1'b1) begin
            cmp(rdata, 64'h0);
        end
    end

    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        conclude();
    end

    initial begin
        {nrst, wr, rd, mc_event, mc_restart_ok, mc_ip_valid, therm_trip} = '0;
        addr = '0;
        wdata = '0;
        perf_status_in = '0;
        seed = 32'hbb21;
        rw_addr = '{12'h199, 12'h19a, 12'h19b};
        rst_addr = '{12'h17a, 12'h199, 12'h19a, 12'h19b, 12'h19c, 12'h19d, 12'h1a0,
                     12'h1f0, 12'h1f1};
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        foreach (rst_addr[i]) rd_reg(rst_addr[i], 64'h0);
        @(negedge mclk);
        cmp({61'h0, therm}, 64'h1);
        foreach (rw_addr[i]) begin
            rnd(vals[i]);
            wr_reg(rw_addr[i], vals[i]);
            rd_reg(rw_addr[i], vals[i]);
        end
        @(negedge mclk);
        cmp(perf_ctl, vals[0]);
        cmp(clk_mod, vals[1]);
        cmp(therm_int, vals[2]);
        rnd(v);
        @(posedge mclk);
        perf_status_in <= v;
        wr_reg(12'h198, ~v);
        rd_reg(12'h198, v);
        wr_reg(12'h1a0, '1);
        rd_reg(12'h1a0, 64'h8);
        wr_reg(12'h19d, '1);
        rd_reg(12'h19d, 64'h10000);
        wr_reg(12'h123, '1);
        rd_reg(12'h123, 64'h0);
        wr_reg(12'h17a, ~64'h7);
        rd_reg(12'h17a, 64'h0);
        therm_trip <= 1'b1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        cmp({61'h0, therm}, 64'h3);
        rd_reg(12'h19c, 64'h3);
        wr_reg(12'h19c, 64'h0);
        rd_reg(12'h19c, 64'h1);
        wr_reg(12'h19d, 64'h0);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        prev_run = therm.clk_run_en;
        cmp({63'h0, therm.duty_cycle_thermal_mode}, 64'h1);
        @(negedge mclk);
        cmp({63'h0, therm.clk_run_en}, {63'h0, ~prev_run});
        wr_reg(12'h1a0, 64'h0);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        cmp({61'h0, therm}, 64'h1);
        @(posedge mclk);
        therm_trip <= 1'b0;
        wr_reg(12'h1f1, 64'h7);
        @(negedge mclk);
        cmp({63'h0, irq}, 64'h1);
        wr_reg(12'h1f0, 64'h4);
        @(posedge mclk);
        @(negedge mclk);
        cmp({63'h0, irq}, 64'h0);
        wr_reg(12'h1f1, 64'h0);
        mc_restart_ok <= 1'b1;
        mc_pulse();
        @(negedge mclk);
        cmp({63'h0, mc_raise}, 64'h1);
        @(negedge mclk);
        cmp({62'h0, mc_raise, irq}, 64'h0);
        rd_reg(12'h17a, 64'h5);
        rd_reg(12'h1f0, 64'h1);
        wr_reg(12'h1f1, 64'h1);
        @(posedge mclk);
        @(negedge mclk);
        cmp({63'h0, irq}, 64'h1);
        wr_reg(12'h1f0, 64'h1);
        wr_reg(12'h17a, 64'h0);
        rd_reg(12'h17a, 64'h0);
        mc_restart_ok <= 1'b0;
        mc_ip_valid <= 1'b1;
        @(negedge mclk);
        cmp({63'h0, irq}, 64'h0);
        mc_pulse();
        @(negedge mclk);
        cmp({62'h0, mc_raise, shutdown}, 64'h2);
        rd_reg(12'h17a, 64'h6);
        mc_pulse();
        @(negedge mclk);
        cmp({62'h0, mc_raise, shutdown}, 64'h1);
        rd_reg(12'h1f0, 64'h3);
        mc_pulse();
        @(negedge mclk);
        cmp({62'h0, mc_raise, shutdown}, 64'h1);
        conclude();
    end
endmodule
`default_nettype wire
